// ---- lpic_top.sv ----
/*
 * Light/proximity sensor control: serial register slave, phase sequencer,
 * emitter drive and interrupt flag/pin.
 * Assumes bus pins and analog counts synchronous to clk_i; bus clock far
 * slower than clk_i; the analog side presents its count on sample_i at phase end.
 */
`timescale 1ns/10ps
module lpic_top #(
    parameter logic [6:0] DEV_ADDR = lpic_pkg::BUS_ADDR,
    parameter int OSC_DIV = lpic_pkg::OSC_DIV_CYC,
    parameter int MOD_HALF = lpic_pkg::MOD_HALF_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial register bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // interrupt
    output logic int_n_o,
    // emitter
    output logic emitter_drive_pin_o,
    output logic [1:0] emitter_level_o,
    // analog front end
    input wire logic [15:0] sample_i,
    output lpic_pkg::lpic_seq_t sense_phase_o
);
    import lpic_pkg::*;

    typedef struct packed {
        lpic_bus_t bus;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic is_addr;
        logic is_ptr;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic scl_d;
        logic sda_d;
        logic sda_oe_n;
        logic sda_out;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [15:0] result;
        logic [15:0] thr_lo;
        logic [15:0] thr_hi;
        lpic_seq_t seq;
        logic [16:0] icnt;
        logic [15:0] ir_raw;
        logic res_valid;
        logic int_n;
        logic emit;
        logic [1:0] level;
    } lpic_state_t;

    lpic_state_t s_reg;
    lpic_state_t s_next;
    logic osc_tick;
    logic mod_wave;
    logic hit;

    // ------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] read_reg(input logic [7:0] a, input lpic_state_t st);
        case (a)
            REG_CTL1: read_reg = st.ctl1;
            REG_CTL2: read_reg = st.ctl2;
            REG_RES_L: read_reg = st.result[7:0];
            REG_RES_H: read_reg = st.result[15:8];
            REG_THR_LO_L: read_reg = st.thr_lo[7:0];
            REG_THR_LO_H: read_reg = st.thr_lo[15:8];
            REG_THR_HI_L: read_reg = st.thr_hi[7:0];
            REG_THR_HI_H: read_reg = st.thr_hi[15:8];
            REG_TEST: read_reg = TEST_VALUE;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    lpic_timebase #(
        .OSC_DIV(OSC_DIV),
        .MOD_HALF(MOD_HALF),
        .CW(8)
    ) u_timebase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_tick_o(osc_tick),
        .mod_wave_o(mod_wave)
    );

    lpic_window u_window (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .valid_i(s_reg.res_valid),
        .value_i(s_reg.result),
        .signed_i(s_reg.ctl2[CTL2_SCHEME_BIT]),
        .lo_i(s_reg.thr_lo),
        .hi_i(s_reg.thr_hi),
        .persist_i(s_reg.ctl1[CTL1_PERSIST_LSB +: 2]),
        .hit_o(hit)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic wr;
        logic load;
        logic clr;
        logic [7:0] rd;
        logic [16:0] diff;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        wr = 1'b0;
        load = 1'b0;
        clr = 1'b0;
        rd = 8'h00;
        diff = {1'b0, sample_i} - {1'b0, s_reg.ir_raw};
        s_next = s_reg;
        s_next.scl_d = scl_i;
        s_next.sda_d = sda_i;
        s_next.res_valid = 1'b0;
        s_next.sda_out = 1'b0;

        // phase sequencer
        case (s_reg.seq)
            SEQ_IDLE: begin
                s_next.icnt = 17'h00000;
                if (s_reg.ctl1[CTL1_RUN_BIT]) begin
                    s_next.seq = SEQ_VIS;
                end
            end
            SEQ_VIS, SEQ_IR, SEQ_PROX: begin
                if (osc_tick) begin
                    if (s_reg.icnt == int_cycles(s_reg.ctl2[CTL2_RES_LSB +: 2]) - 17'h00001) begin
                        s_next.icnt = 17'h00000;
                        s_next.res_valid = 1'b1;
                        case (s_reg.seq)
                            SEQ_VIS: begin
                                s_next.result = sample_i;
                                s_next.seq = SEQ_IR;
                            end
                            SEQ_IR: begin
                                s_next.ir_raw = sample_i;
                                s_next.result = sample_i;
                                s_next.seq = SEQ_PROX;
                            end
                            default: begin
                                if (s_reg.ctl2[CTL2_SCHEME_BIT]) begin
                                    s_next.result = diff[16:1];
                                end else begin
                                    s_next.result = sample_i;
                                end
                                s_next.seq = s_reg.ctl1[CTL1_RUN_BIT] ? SEQ_VIS : SEQ_IDLE;
                            end
                        endcase
                    end else begin
                        s_next.icnt = s_reg.icnt + 17'h00001;
                    end
                end
            end
            default: s_next.seq = SEQ_IDLE;
        endcase

        // serial bus slave
        rise = scl_i & ~s_reg.scl_d;
        fall = ~scl_i & s_reg.scl_d;
        start = scl_i & s_reg.scl_d & s_reg.sda_d & ~sda_i;
        stop = scl_i & s_reg.scl_d & ~s_reg.sda_d & sda_i;
        if (start) begin
            s_next.bus = BUS_RX;
            s_next.bitcnt = 4'h0;
            s_next.is_addr = 1'b1;
            s_next.is_ptr = 1'b0;
            s_next.sda_oe_n = 1'b1;
        end else if (stop) begin
            s_next.bus = BUS_IDLE;
            s_next.sda_oe_n = 1'b1;
        end else begin
            case (s_reg.bus)
                BUS_IDLE: s_next.sda_oe_n = 1'b1;
                BUS_RX: begin
                    if (rise) begin
                        s_next.shift = {s_reg.shift[6:0], sda_i};
                        s_next.bitcnt = s_reg.bitcnt + 4'h1;
                    end else if (fall && s_reg.bitcnt == 4'h8) begin
                        if (s_reg.is_addr) begin
                            if (s_reg.shift[7:1] == DEV_ADDR) begin
                                s_next.rw = s_reg.shift[0];
                                s_next.is_ptr = ~s_reg.shift[0];
                                s_next.sda_oe_n = 1'b0;
                                s_next.bus = BUS_ACK;
                            end else begin
                                s_next.bus = BUS_IDLE;
                            end
                        end else begin
                            if (s_reg.is_ptr) begin
                                s_next.ptr = s_reg.shift;
                                s_next.is_ptr = 1'b0;
                            end else begin
                                wr = 1'b1;
                                s_next.ptr = s_reg.ptr + 8'h01;
                            end
                            s_next.sda_oe_n = 1'b0;
                            s_next.bus = BUS_ACK;
                        end
                    end
                end
                BUS_ACK: begin
                    if (fall) begin
                        s_next.sda_oe_n = 1'b1;
                        if (s_reg.is_addr && s_reg.rw) begin
                            load = 1'b1;
                        end else begin
                            s_next.bus = BUS_RX;
                            s_next.bitcnt = 4'h0;
                        end
                        s_next.is_addr = 1'b0;
                    end
                end
                BUS_TX: begin
                    if (fall) begin
                        if (s_reg.bitcnt == 4'h7) begin
                            s_next.sda_oe_n = 1'b1;
                            s_next.bus = BUS_TXACK;
                        end else begin
                            s_next.shift = {s_reg.shift[6:0], 1'b0};
                            s_next.bitcnt = s_reg.bitcnt + 4'h1;
                            s_next.sda_oe_n = s_reg.shift[6];
                        end
                    end
                end
                BUS_TXACK: begin
                    if (rise) begin
                        s_next.nack = sda_i;
                    end else if (fall) begin
                        if (s_reg.nack) begin
                            s_next.bus = BUS_IDLE;
                        end else begin
                            load = 1'b1;
                        end
                    end
                end
                default: s_next.bus = BUS_IDLE;
            endcase
        end

        // byte load for reads; reading control_one clears the flag
        if (load) begin
            rd = read_reg(s_reg.ptr, s_reg);
            s_next.shift = rd;
            s_next.sda_oe_n = rd[7];
            s_next.bitcnt = 4'h0;
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.bus = BUS_TX;
            if (s_reg.ptr == REG_CTL1) begin
                clr = 1'b1;
            end
        end

        // register writes
        if (wr) begin
            case (s_reg.ptr)
                REG_CTL1: begin
                    s_next.ctl1[7:3] = s_reg.shift[7:3];
                    s_next.ctl1[1:0] = s_reg.shift[1:0];
                    if (!s_reg.shift[CTL1_FLAG_BIT]) begin
                        clr = 1'b1;
                    end
                end
                REG_CTL2: s_next.ctl2 = s_reg.shift;
                REG_THR_LO_L: s_next.thr_lo[7:0] = s_reg.shift;
                REG_THR_LO_H: s_next.thr_lo[15:8] = s_reg.shift;
                REG_THR_HI_L: s_next.thr_hi[7:0] = s_reg.shift;
                REG_THR_HI_H: s_next.thr_hi[15:8] = s_reg.shift;
                default: s_next.ctl2 = s_reg.ctl2;
            endcase
        end

        // flag: a new event wins over a clear in the same cycle
        if (hit) begin
            s_next.ctl1[CTL1_FLAG_BIT] = 1'b1;
        end else if (clr) begin
            s_next.ctl1[CTL1_FLAG_BIT] = 1'b0;
        end
        s_next.int_n = ~s_next.ctl1[CTL1_FLAG_BIT];

        // emitter only in proximity phase
        if (s_next.seq == SEQ_PROX) begin
            s_next.emit = s_reg.ctl2[CTL2_MOD_BIT] ? mod_wave : 1'b1;
        end else begin
            s_next.emit = 1'b0;
        end
        s_next.level = s_reg.ctl2[CTL2_DRIVE_LSB +: 2];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.bus <= BUS_IDLE;
            s_reg.seq <= SEQ_IDLE;
            s_reg.scl_d <= 1'b1;
            s_reg.sda_d <= 1'b1;
            s_reg.sda_oe_n <= 1'b1;
            s_reg.ctl1 <= CTL1_RST;
            s_reg.ctl2 <= CTL2_RST;
            s_reg.thr_lo <= THR_LO_RST;
            s_reg.thr_hi <= THR_HI_RST;
            s_reg.int_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sda_o = s_reg.sda_out;
    assign sda_oe_n_o = s_reg.sda_oe_n;
    assign int_n_o = s_reg.int_n;
    assign emitter_drive_pin_o = s_reg.emit;
    assign emitter_level_o = s_reg.level;
    assign sense_phase_o = s_reg.seq;

endmodule

// ---- lpic_pkg.sv ----
/*
 * Constants, types and decode functions for the light/proximity
 * interrupt and emitter control block.
 * Assumes a 125 MHz system clock and 8-bit registers on a two-wire serial bus.
 */
package lpic_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTL1 = 8'h00;
    localparam logic [7:0] REG_CTL2 = 8'h01;
    localparam logic [7:0] REG_RES_L = 8'h02;
    localparam logic [7:0] REG_RES_H = 8'h03;
    localparam logic [7:0] REG_THR_LO_L = 8'h04;
    localparam logic [7:0] REG_THR_LO_H = 8'h05;
    localparam logic [7:0] REG_THR_HI_L = 8'h06;
    localparam logic [7:0] REG_THR_HI_H = 8'h07;
    localparam logic [7:0] REG_TEST = 8'h08;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL1_RUN_BIT = 7;
    localparam int CTL1_FLAG_BIT = 2;
    localparam int CTL1_PERSIST_LSB = 0;
    localparam int CTL2_SCHEME_BIT = 7;
    localparam int CTL2_MOD_BIT = 6;
    localparam int CTL2_DRIVE_LSB = 4;
    localparam int CTL2_RES_LSB = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [15:0] THR_LO_RST = 16'h0000;
    localparam logic [15:0] THR_HI_RST = 16'hFFFF;
    localparam logic [7:0] TEST_VALUE = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int OSC_FREQ_KHZ = 725;
    localparam int OSC_DIV_CYC = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
    localparam int MOD_FREQ_KHZ = 360;
    localparam int MOD_HALF_CYC = CLK_FREQ_KHZ / (2 * MOD_FREQ_KHZ);
    localparam logic [6:0] BUS_ADDR = 7'h44;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_VIS = 2'b01,
        SEQ_IR = 2'b10,
        SEQ_PROX = 2'b11
    } lpic_seq_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_RX = 3'b001,
        BUS_ACK = 3'b010,
        BUS_TX = 3'b011,
        BUS_TXACK = 3'b100
    } lpic_bus_t;

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic logic [4:0] persist_need(input logic [1:0] code);
        case (code)
            2'b00: persist_need = 5'h01;
            2'b01: persist_need = 5'h04;
            2'b10: persist_need = 5'h08;
            default: persist_need = 5'h10;
        endcase
    endfunction

    function automatic logic [16:0] int_cycles(input logic [1:0] code);
        case (code)
            2'b00: int_cycles = 17'h10000;
            2'b01: int_cycles = 17'h01000;
            2'b10: int_cycles = 17'h00100;
            default: int_cycles = 17'h00010;
        endcase
    endfunction

endpackage

// ---- lpic_timebase.sv ----
/*
 * Time base: conversion clock ticks and emitter modulation square wave.
 * Assumes the system clock runs at the rate given in the package.
 */
`timescale 1ns/10ps
module lpic_timebase #(
    parameter int OSC_DIV = lpic_pkg::OSC_DIV_CYC,
    parameter int MOD_HALF = lpic_pkg::MOD_HALF_CYC,
    parameter int CW = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // time base outputs
    output logic osc_tick_o,
    output logic mod_wave_o
);
    import lpic_pkg::*;

    typedef struct packed {
        logic [CW-1:0] osc_cnt;
        logic [CW-1:0] mod_cnt;
        logic tick;
        logic wave;
    } lpic_tb_t;

    lpic_tb_t s_reg;
    lpic_tb_t s_next;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.osc_cnt == CW'(OSC_DIV - 1)) begin
            s_next.osc_cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.osc_cnt = s_reg.osc_cnt + CW'(1);
        end
        if (s_reg.mod_cnt == CW'(MOD_HALF - 1)) begin
            s_next.mod_cnt = '0;
            s_next.wave = ~s_reg.wave;
        end else begin
            s_next.mod_cnt = s_reg.mod_cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign osc_tick_o = s_reg.tick;
    assign mod_wave_o = s_reg.wave;

endmodule

// ---- lpic_window.sv ----
/*
 * Threshold window check with persistence counting.
 * Assumes one valid pulse per finished integration.
 */
`timescale 1ns/10ps
module lpic_window (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // result in
    input wire logic valid_i,
    input wire logic [15:0] value_i,
    input wire logic signed_i,
    // settings
    input wire logic [15:0] lo_i,
    input wire logic [15:0] hi_i,
    input wire logic [1:0] persist_i,
    // event out
    output logic hit_o
);
    import lpic_pkg::*;

    typedef struct packed {
        logic [4:0] cnt;
        logic hit;
    } lpic_win_t;

    lpic_win_t s_reg;
    lpic_win_t s_next;
    logic outside;

    // ------------------------------------------------------------
    // compare and count
    // ------------------------------------------------------------
    always_comb begin
        if (signed_i) begin
            outside = ($signed(value_i) < $signed(lo_i)) || ($signed(value_i) > $signed(hi_i));
        end else begin
            outside = (value_i < lo_i) || (value_i > hi_i);
        end
        s_next = s_reg;
        s_next.hit = 1'b0;
        if (valid_i) begin
            if (!outside) begin
                s_next.cnt = 5'h00;
            end else if (s_reg.cnt + 5'h01 >= persist_need(persist_i)) begin
                s_next.cnt = 5'h00;
                s_next.hit = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hit_o = s_reg.hit;

endmodule

// ---- lpic_sva.sv ----
/* Port checks for lpic_top, bound to every instance.
   Assumes a serial bus clock far slower than clk_i. */
`timescale 1ns/10ps
module lpic_sva (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_oe_n_o,
    input wire logic int_n_o,
    input wire logic emitter_drive_pin_o,
    input wire lpic_pkg::lpic_seq_t sense_phase_o
);
    import lpic_pkg::*;
    logic [7:0] age;
    lpic_seq_t ph_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ----------------
    // cycles since the phase last moved
    // ----------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= SEQ_IDLE;
            age <= 8'h00;
        end else begin
            ph_q <= sense_phase_o;
            age <= (ph_q != sense_phase_o) ? 8'h00 : age + {7'h00, age != 8'hFF};
        end
    end
    a_reset_idle:
        assert property ($fell(rst_i) |-> int_n_o && sda_oe_n_o && sense_phase_o == SEQ_IDLE)
        else $error("outputs not idle after reset");
    a_emit_in_prox:
        assert property (emitter_drive_pin_o |-> sense_phase_o == SEQ_PROX
            || $past(sense_phase_o) == SEQ_PROX) else $error("emitter on outside proximity");
    a_ir_after_vis:
        assert property (sense_phase_o == SEQ_IR && $past(sense_phase_o) != SEQ_IR
            |-> $past(sense_phase_o) == SEQ_VIS) else $error("infrared not after visible");
    a_prox_after_ir:
        assert property (sense_phase_o == SEQ_PROX && $past(sense_phase_o) != SEQ_PROX
            |-> $past(sense_phase_o) == SEQ_IR) else $error("proximity not after infrared");
    a_vis_entry:
        assert property (sense_phase_o == SEQ_VIS && $past(sense_phase_o) != SEQ_VIS
            |-> $past(sense_phase_o) == SEQ_IDLE || $past(sense_phase_o) == SEQ_PROX)
        else $error("cycle ran backwards");
    a_pin_clear_bus:
        assert property ($rose(int_n_o) |-> !scl_i) else $error("pin released off the bus");
    a_pin_after_result:
        assert property ($fell(int_n_o) |-> age <= 8'h08) else $error("pin not after a result");
    a_drive_scl_low:
        assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("data moved with clock high");
    c_pin_fall: cover property ($fell(int_n_o));
    c_pin_rise: cover property ($rose(int_n_o));
    c_emit_on: cover property (sense_phase_o == SEQ_PROX && emitter_drive_pin_o);
endmodule
bind lpic_top lpic_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
    .sda_oe_n_o(sda_oe_n_o), .int_n_o(int_n_o), .emitter_drive_pin_o(emitter_drive_pin_o),
    .sense_phase_o(sense_phase_o));

// ---- lpic_host.sv ----
/* Serial bus controller model for the register bus.
   Assumes a pull-up on the data wire and clk_i far faster than the bus. */
`timescale 1ns/10ps
module lpic_host #(
    parameter int H = 8
) (
    // clock
    input wire logic clk_i,
    // device side of the open drain data wire
    input wire logic sda_oe_n_i,
    input wire logic sda_dev_i,
    // resolved bus
    output logic scl_o,
    output logic sda_o
);
    logic drv = 1'b1;
    initial scl_o = 1'b1;
    // wired-and with pull-up
    assign sda_o = drv & (sda_oe_n_i | sda_dev_i);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // also a repeated start
    task automatic start();
        drv <= 1'b1;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        drv <= 1'b0;
        tick(H);
        scl_o <= 1'b0;
        tick(H);
    endtask
    task automatic stop();
        drv <= 1'b0;
        tick(H);
        scl_o <= 1'b1;
        tick(H);
        drv <= 1'b1;
        tick(2 * H);
    endtask
    // eight bits then the acknowledge bit; send 8'hFF to read
    task automatic xbyte(input logic [7:0] d, input logic ak_i, output logic [7:0] q,
        output logic ak_o);
        logic [8:0] w;
        w = {d, ak_i};
        for (int i = 8; i >= 0; i--) begin
            drv <= w[i];
            tick(H);
            scl_o <= 1'b1;
            tick(H);
            w[i] = sda_o;
            scl_o <= 1'b0;
        end
        q = w[8:1];
        ak_o = w[0];
    endtask
endmodule

// ---- tb.sv ----
/* Self-checking bench for lpic_top with a bus controller model and
   per-phase analog counts. Assumes the package, host model and checker. */
`timescale 1ns/10ps
module tb;
    import lpic_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic scl, sda, sda_o, sda_oe_n_o, int_n_o, emitter_drive_pin_o;
    logic em_q = 1'b0;
    logic [1:0] emitter_level_o, lvl;
    logic [15:0] sample_i = 16'h0000;
    logic [15:0] vis_v = 16'h0000, ir_v = 16'h0000, px_v = 16'h0000;
    logic [7:0] rb [10];
    logic [7:0] thr [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
    lpic_seq_t sense_phase_o, ph_q = SEQ_IDLE;
    int fails = 0, comparisons = 0, results = 0, rises = 0, base;
    always #4 clk_i = ~clk_i;
    lpic_top #(.OSC_DIV(2), .MOD_HALF(3)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .int_n_o(int_n_o),
        .emitter_drive_pin_o(emitter_drive_pin_o), .emitter_level_o(emitter_level_o),
        .sample_i(sample_i), .sense_phase_o(sense_phase_o));
    lpic_host u_host (.clk_i(clk_i), .sda_oe_n_i(sda_oe_n_o), .sda_dev_i(sda_o), .scl_o(scl),
        .sda_o(sda));
    // ----------------
    // analog counts per phase, results and emitter pulses seen
    // ----------------
    always @(posedge clk_i) begin
        sample_i <= ph_q == SEQ_IR ? ir_v : (ph_q == SEQ_PROX ? px_v : vis_v);
    end
    always @(negedge clk_i) begin
        ph_q <= sense_phase_o;
        em_q <= emitter_drive_pin_o;
        if (ph_q != SEQ_IDLE && ph_q != sense_phase_o) begin
            results <= results + 1;
            check("order", 16'(sense_phase_o),
                16'(ph_q == SEQ_PROX ? sense_phase_o & 2'b01 : ph_q + 2'b01));
        end
        if (sense_phase_o == SEQ_VIS) rises <= 0;
        else if (emitter_drive_pin_o && !em_q) rises <= rises + 1;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] q;
        logic ak;
        u_host.start();
        u_host.xbyte({BUS_ADDR, 1'b0}, 1'b1, q, ak);
        u_host.xbyte(p, 1'b1, q, ak);
        u_host.xbyte(d, 1'b1, q, ak);
        check("ack", 16'(ak), 16'h0000);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        logic [7:0] q;
        logic ak;
        u_host.start();
        u_host.xbyte({BUS_ADDR, 1'b0}, 1'b1, q, ak);
        u_host.xbyte(p, 1'b1, q, ak);
        u_host.start();
        u_host.xbyte({BUS_ADDR, 1'b1}, 1'b1, q, ak);
        for (int i = 0; i < n; i++) u_host.xbyte(8'hFF, i == n - 1, rb[i], ak);
        u_host.stop();
    endtask
    task automatic wait_res(input int n);
        int t;
        t = results + n;
        for (int k = 0; k < 5000 && results < t; k++) @(posedge clk_i);
        check("results", 16'(results >= t), 16'h0001);
        repeat (6) @(posedge clk_i);
    endtask
    initial begin
        #(8 * 80000);
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(54));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(8'h00, 10);
        for (int i = 0; i < 10; i++) check("reset", rb[i], (i == 6 || i == 7) ? 16'h00FF : 16'h0000);
        for (int i = 0; i < 4; i++) wr(8'h04 + 8'(i), thr[i]);
        {vis_v, ir_v, px_v} = {3{16'h0150}};
        wr(8'h01, 8'h0C);
        wr(8'h00, 8'h81);
        wait_res(1);
        {vis_v, ir_v, px_v} = {3{16'h0300}};
        wait_res(3);
        check("pin early", 16'(int_n_o), 16'h0001);
        wait_res(1);
        check("pin", 16'(int_n_o), 16'h0000);
        {vis_v, ir_v, px_v} = {3{16'h0150}};
        rd(8'h00, 1);
        check("flag", rb[0], 16'h0085);
        check("pin cleared", 16'(int_n_o), 16'h0001);
        for (int s = 0; s < 4; s++) begin
            lvl = 2'($urandom);
            ir_v = 16'($urandom_range(16'h3FFF));
            px_v = ir_v + 16'($urandom_range(16'h3FFF));
            vis_v = 16'($urandom);
            wr(8'h01, {s[1], s[0], lvl, 2'b11, 2'b00});
            check("level", 16'(emitter_level_o), 16'(lvl));
            wr(8'h00, 8'h80);
            wr(8'h00, 8'h00);
            for (int k = 0; k < 2000 && sense_phase_o !== SEQ_IDLE; k++) @(posedge clk_i);
            repeat (4) @(posedge clk_i);
            check("idle", 16'(sense_phase_o), 16'(SEQ_IDLE));
            check("modulation", 16'(rises > 2), 16'(s[0]));
            rd(8'h02, 2);
            check("result", {rb[1], rb[0]} - (s[1] ? 16'h0000 : ir_v),
                (px_v - ir_v) >> s[1]);
        end
        stop_test();
    end
endmodule
